// >>> desel_pkg.sv
// desel_pkg: constants for the dma event-to-channel selector
// assumes one 40 mhz clock domain and a plain register port
package desel_pkg;
	// ========================================
	// geometry
	localparam int NUM_CHANNELS = 16;
	localparam int CODE_W = 6;
	localparam int NUM_EVENTS = 64;
	localparam int FIELDS_PER_REG = 4;
	localparam int FIELD_STRIDE = 8;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	// ========================================
	// register addresses
	localparam logic [31:0] ADDR_SEL_CH0_3 = 32'h01a0ff00;
	localparam logic [31:0] ADDR_SEL_CH4_7 = 32'h01a0ff04;
	localparam logic [31:0] ADDR_SEL_CH12_15 = 32'h01a0ff0c;
	// ========================================
	// field layout: four 6-bit fields at 8-bit stride
	localparam logic [31:0] SEL_FIELD_MASK = 32'h3f3f3f3f;
	// ========================================
	// reset values: each field equals its channel number
	localparam logic [31:0] RST_SEL_CH0_3 = 32'h03020100;
	localparam logic [31:0] RST_SEL_CH4_7 = 32'h07060504;
	localparam logic [31:0] RST_SEL_CH12_15 = 32'h0f0e0d0c;
	// ========================================
	// chaining channels
	localparam int CHAIN_FIRST = 8;
	localparam int CHAIN_LAST = 11;
	// ========================================
	// selector codes
	localparam logic [5:0] CODE_HOST = 6'h00;
	localparam logic [5:0] CODE_TIMER0 = 6'h01;
	localparam logic [5:0] CODE_TIMER1 = 6'h02;
	localparam logic [5:0] CODE_MEMIF = 6'h03;
	localparam logic [5:0] CODE_GPIO4 = 6'h04;
	localparam logic [5:0] CODE_GPIO0 = 6'h08;
	localparam logic [5:0] CODE_BSP0_TX = 6'h0c;
	localparam logic [5:0] CODE_ASP0_FIRST = 6'h20;
	localparam logic [5:0] CODE_ASP1_FIRST = 6'h26;
	localparam logic [5:0] CODE_I2C0_RX = 6'h2c;
	localparam logic [5:0] CODE_GPIO8 = 6'h30;
	localparam logic [5:0] CODE_RSVD_A_LO = 6'h10;
	localparam logic [5:0] CODE_RSVD_A_HI = 6'h1f;
	localparam logic [5:0] CODE_RSVD_B_LO = 6'h38;
	// ========================================
	// gpio
	localparam int NUM_GPIO = 16;
	localparam int GPIO_IND_LO = 4;
	localparam int GPIO_IND_HI = 7;
endpackage

// >>> desel_event_vector.sv
// desel_event_vector: packs the peripheral events into one vector indexed by selector code
// assumes event inputs are one-cycle pulses synchronous to clock
`timescale 1ns/1ps
module desel_event_vector (
	// system
	input wire logic clock,
	input wire logic rst_n,
	// peripheral events
	input wire logic host_to_processor_event,
	input wire logic timer_zero_event,
	input wire logic timer_one_event,
	input wire logic memory_interface_event,
	input wire logic [3:0] bsp_event,
	input wire logic [11:0] asp_event,
	input wire logic [3:0] i2c_event,
	input wire logic [15:0] general_pin,
	input wire logic [15:0] gpio_pin_event,
	input wire logic [15:0] combined_gpio_enable,
	// result, registered
	output logic [63:0] event_vec
);
	logic [63:0] vec_next;
	logic combined_gpio_event;

	// ========================================
	// vector build
	always_comb begin
		// any enabled pin drives the combined event 0
		combined_gpio_event = |(general_pin & combined_gpio_enable);
		vec_next = '0;
		vec_next[desel_pkg::CODE_HOST] = host_to_processor_event;
		vec_next[desel_pkg::CODE_TIMER0] = timer_zero_event;
		vec_next[desel_pkg::CODE_TIMER1] = timer_one_event;
		vec_next[desel_pkg::CODE_MEMIF] = memory_interface_event;
		// pins 4..7 alternatively give individual events
		vec_next[desel_pkg::CODE_GPIO4 +: 4] = gpio_pin_event[7:4];
		vec_next[desel_pkg::CODE_GPIO0] = combined_gpio_event | gpio_pin_event[0];
		vec_next[desel_pkg::CODE_GPIO0 + 6'h01 +: 3] = gpio_pin_event[3:1];
		vec_next[desel_pkg::CODE_BSP0_TX +: 4] = bsp_event;
		vec_next[desel_pkg::CODE_ASP0_FIRST +: 12] = asp_event;
		vec_next[desel_pkg::CODE_I2C0_RX +: 4] = i2c_event;
		vec_next[desel_pkg::CODE_GPIO8 +: 8] = gpio_pin_event[15:8];
		// reserved codes 0x10..0x1f and 0x38..0x3f stay zero
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			event_vec <= '0;
		end else begin
			event_vec <= vec_next;
		end
	end
endmodule

// >>> desel_selector.sv
// Contract
// - sixteen channels; 8 to 11 chain only, twelve mappable by selector.
// - three selector registers at 0x01a0ff00, 0x01a0ff04, 0x01a0ff0c.
// - each mappable channel triggered by the event its 6-bit code names.
// - fields at bits 5:0, 13:8, 21:16, 29:24 in ascending channel order.
// - after reset each field holds its own channel number.
// - codes 0-3 host, timers, memory; codes 4-7 gpio events 4-7.
// - codes 8-11 gpio 0-3; codes 0x30-0x37 gpio 8-15.
// - codes 0x0c-0x0f buffered serial port transmit/receive events.
// - codes 0x20-0x2b audio serial port events, six per port.
// - codes 0x2c-0x2f i2c receive/transmit events, two controllers.
// - enabled pins feed combined gpio event 0; pins 4-7 feed individual events.
// - event sources are controlled by their owning module.
// - reserved bits read zero, writes ignored.
//
// desel_selector: selector registers and channel trigger routing
// assumes the register master never issues read and write together
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module desel_selector (
	// system
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// peripheral events, owned and gated by their own modules
	input wire logic host_to_processor_event,
	input wire logic timer_zero_event,
	input wire logic timer_one_event,
	input wire logic memory_interface_event,
	input wire logic [3:0] bsp_event,
	input wire logic [11:0] asp_event,
	input wire logic [3:0] i2c_event,
	input wire logic [15:0] general_pin,
	input wire logic [15:0] gpio_pin_event,
	input wire logic [15:0] combined_gpio_enable,
	// chaining completion codes for channels 8..11
	input wire logic [3:0] chain_complete_code,
	// channel triggers
	output logic [15:0] channel_trigger,
	// code sanity
	output logic [15:0] channel_code_reserved
);
	// ========================================
	// state
	logic [31:0] sel_ch0_3_reg, sel_ch0_3_next;
	logic [31:0] sel_ch4_7_reg, sel_ch4_7_next;
	logic [31:0] sel_ch12_15_reg, sel_ch12_15_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [15:0] trig_reg, trig_next;
	logic [15:0] rsv_reg, rsv_next;
	logic [63:0] event_vec;
	logic [5:0] channel_event_code [16];

	// ========================================
	// helpers
	function automatic logic [5:0] field_of(input logic [31:0] r, input int idx);
		field_of = r[idx * desel_pkg::FIELD_STRIDE +: desel_pkg::CODE_W];
	endfunction

	function automatic logic code_is_reserved(input logic [5:0] c);
		code_is_reserved = (c >= desel_pkg::CODE_RSVD_A_LO && c <= desel_pkg::CODE_RSVD_A_HI)
			|| (c >= desel_pkg::CODE_RSVD_B_LO);
	endfunction

	function automatic logic addr_is_mapped(input logic [31:0] a);
		addr_is_mapped = a == desel_pkg::ADDR_SEL_CH0_3 || a == desel_pkg::ADDR_SEL_CH4_7
			|| a == desel_pkg::ADDR_SEL_CH12_15;
	endfunction

	// ========================================
	// event vector
	desel_event_vector u_vec (
		.clock(clock),
		.rst_n(rst_n),
		.host_to_processor_event(host_to_processor_event),
		.timer_zero_event(timer_zero_event),
		.timer_one_event(timer_one_event),
		.memory_interface_event(memory_interface_event),
		.bsp_event(bsp_event),
		.asp_event(asp_event),
		.i2c_event(i2c_event),
		.general_pin(general_pin),
		.gpio_pin_event(gpio_pin_event),
		.combined_gpio_enable(combined_gpio_enable),
		.event_vec(event_vec)
	);

	// ========================================
	// registers
	always_comb begin
		sel_ch0_3_next = sel_ch0_3_reg;
		sel_ch4_7_next = sel_ch4_7_reg;
		sel_ch12_15_next = sel_ch12_15_reg;
		rdata_next = '0;
		if (reg_write) begin
			// mask keeps reserved bits at zero
			unique case (reg_addr)
				desel_pkg::ADDR_SEL_CH0_3:
					sel_ch0_3_next = reg_wdata & desel_pkg::SEL_FIELD_MASK;
				desel_pkg::ADDR_SEL_CH4_7:
					sel_ch4_7_next = reg_wdata & desel_pkg::SEL_FIELD_MASK;
				desel_pkg::ADDR_SEL_CH12_15:
					sel_ch12_15_next = reg_wdata & desel_pkg::SEL_FIELD_MASK;
				default: begin
				end
			endcase
		end
		if (reg_read) begin
			// unmapped addresses read zero
			unique case (reg_addr)
				desel_pkg::ADDR_SEL_CH0_3: rdata_next = sel_ch0_3_reg;
				desel_pkg::ADDR_SEL_CH4_7: rdata_next = sel_ch4_7_reg;
				desel_pkg::ADDR_SEL_CH12_15: rdata_next = sel_ch12_15_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_ch0_3_reg <= desel_pkg::RST_SEL_CH0_3;
			sel_ch4_7_reg <= desel_pkg::RST_SEL_CH4_7;
			sel_ch12_15_reg <= desel_pkg::RST_SEL_CH12_15;
			rdata_reg <= '0;
		end else begin
			sel_ch0_3_reg <= sel_ch0_3_next;
			sel_ch4_7_reg <= sel_ch4_7_next;
			sel_ch12_15_reg <= sel_ch12_15_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ========================================
	// routing
	// chaining channels hold a dummy code; they never use the event vector
	always_comb begin
		for (int i = 0; i < desel_pkg::FIELDS_PER_REG; i++) begin
			channel_event_code[i] = field_of(sel_ch0_3_reg, i);
			channel_event_code[i + desel_pkg::FIELDS_PER_REG] = field_of(sel_ch4_7_reg, i);
			channel_event_code[i + desel_pkg::CHAIN_FIRST] = '0;
			channel_event_code[i + desel_pkg::CHAIN_LAST + 1] = field_of(sel_ch12_15_reg, i);
		end
	end

	always_comb begin
		trig_next = '0;
		rsv_next = '0;
		for (int ch = 0; ch < desel_pkg::NUM_CHANNELS; ch++) begin
			if (ch >= desel_pkg::CHAIN_FIRST && ch <= desel_pkg::CHAIN_LAST) begin
				trig_next[ch] = chain_complete_code[ch - desel_pkg::CHAIN_FIRST];
			end else begin
				rsv_next[ch] = code_is_reserved(channel_event_code[ch]);
				// reserved slots of the vector are zero, so no trigger there
				trig_next[ch] = event_vec[channel_event_code[ch]];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trig_reg <= '0;
			rsv_reg <= '0;
		end else begin
			trig_reg <= trig_next;
			rsv_reg <= rsv_next;
		end
	end

	assign channel_trigger = trig_reg;
	assign channel_code_reserved = rsv_reg;

	// ========================================
	// checks
	sequence s_write_ch0_3;
		reg_write && reg_addr == desel_pkg::ADDR_SEL_CH0_3;
	endsequence

	sequence s_write_ch4_7;
		reg_write && reg_addr == desel_pkg::ADDR_SEL_CH4_7;
	endsequence

	sequence s_write_ch12_15;
		reg_write && reg_addr == desel_pkg::ADDR_SEL_CH12_15;
	endsequence

	// checked while reset is held, so these two carry no disable
	a_reset_selectors: assert property (@(posedge clock)
		!rst_n |-> sel_ch0_3_reg == desel_pkg::RST_SEL_CH0_3
		&& sel_ch4_7_reg == desel_pkg::RST_SEL_CH4_7
		&& sel_ch12_15_reg == desel_pkg::RST_SEL_CH12_15)
		else $error("selector reset value wrong");

	a_reset_quiet: assert property (@(posedge clock)
		!rst_n |-> channel_trigger == 16'h0000 && channel_code_reserved == 16'h0000
		&& reg_rdata == 32'h00000000)
		else $error("outputs active during reset");

	a_write_masked: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_ch0_3 |=> sel_ch0_3_reg == ($past(reg_wdata) & desel_pkg::SEL_FIELD_MASK))
		else $error("selector write not masked");

	a_write_masked_mid: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_ch4_7 |=> sel_ch4_7_reg == ($past(reg_wdata) & desel_pkg::SEL_FIELD_MASK))
		else $error("selector write not masked");

	a_write_masked_high: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_ch12_15 |=> sel_ch12_15_reg == ($past(reg_wdata) & desel_pkg::SEL_FIELD_MASK))
		else $error("selector write not masked");

	a_unmapped_write: assert property (@(posedge clock) disable iff (!rst_n)
		reg_write && !addr_is_mapped(reg_addr) |=> sel_ch0_3_reg == $past(sel_ch0_3_reg)
		&& sel_ch4_7_reg == $past(sel_ch4_7_reg) && sel_ch12_15_reg == $past(sel_ch12_15_reg))
		else $error("unmapped write changed a selector");

	a_read_data: assert property (@(posedge clock) disable iff (!rst_n)
		reg_read && reg_addr == desel_pkg::ADDR_SEL_CH4_7 |=> reg_rdata == $past(sel_ch4_7_reg))
		else $error("read data mismatch");

	a_read_low_data: assert property (@(posedge clock) disable iff (!rst_n)
		reg_read && reg_addr == desel_pkg::ADDR_SEL_CH0_3 |=> reg_rdata == $past(sel_ch0_3_reg))
		else $error("read data mismatch");

	a_read_high_data: assert property (@(posedge clock) disable iff (!rst_n)
		reg_read && reg_addr == desel_pkg::ADDR_SEL_CH12_15 |=> reg_rdata == $past(sel_ch12_15_reg))
		else $error("read data mismatch");

	a_read_idle_zero: assert property (@(posedge clock) disable iff (!rst_n)
		!reg_read |=> reg_rdata == 32'h00000000)
		else $error("read data outside its cycle");

	a_read_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rdata[31:30] == 2'h0 && reg_rdata[23:22] == 2'h0
		&& reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
		else $error("reserved bits read nonzero");

	a_chain_trigger: assert property (@(posedge clock) disable iff (!rst_n)
		chain_complete_code[2] |=> channel_trigger[10])
		else $error("chain trigger lost");

	a_chain_only: assert property (@(posedge clock) disable iff (!rst_n)
		chain_complete_code == 4'h0 |=> channel_trigger[desel_pkg::CHAIN_LAST:desel_pkg::CHAIN_FIRST] == 4'h0)
		else $error("chaining channel triggered by an event");

	a_chain_no_code: assert property (@(posedge clock) disable iff (!rst_n)
		channel_code_reserved[desel_pkg::CHAIN_LAST:desel_pkg::CHAIN_FIRST] == 4'h0)
		else $error("chaining channel flagged reserved");

	a_route_ch15: assert property (@(posedge clock) disable iff (!rst_n)
		##1 channel_trigger[15] == $past(event_vec[sel_ch12_15_reg[29:24]]))
		else $error("channel 15 routing wrong");

	a_reserved_silent: assert property (@(posedge clock) disable iff (!rst_n)
		channel_code_reserved[0] |-> !channel_trigger[0])
		else $error("reserved code triggered");

	a_reserved_flag_low: assert property (@(posedge clock) disable iff (!rst_n)
		field_of(sel_ch12_15_reg, 0) == desel_pkg::CODE_RSVD_A_LO |=> channel_code_reserved[12])
		else $error("reserved code not flagged");

	a_reserved_flag_high: assert property (@(posedge clock) disable iff (!rst_n)
		field_of(sel_ch0_3_reg, 0) >= desel_pkg::CODE_RSVD_B_LO |=> channel_code_reserved[0])
		else $error("reserved code not flagged");

	a_timer_path: assert property (@(posedge clock) disable iff (!rst_n)
		timer_zero_event && field_of(sel_ch0_3_reg, 1) == desel_pkg::CODE_TIMER0
		&& !reg_write |=> ##1 channel_trigger[1])
		else $error("timer event not routed");

	a_gpio4_path: assert property (@(posedge clock) disable iff (!rst_n)
		gpio_pin_event[4] && field_of(sel_ch4_7_reg, 0) == desel_pkg::CODE_GPIO4
		&& !reg_write |=> ##1 channel_trigger[4])
		else $error("gpio 4 event not routed");

	a_bsp_path: assert property (@(posedge clock) disable iff (!rst_n)
		bsp_event[0] && field_of(sel_ch0_3_reg, 0) == desel_pkg::CODE_BSP0_TX
		&& !reg_write |=> ##1 channel_trigger[0])
		else $error("serial port event not routed");

	a_asp_path: assert property (@(posedge clock) disable iff (!rst_n)
		asp_event[0] && field_of(sel_ch4_7_reg, 0) == desel_pkg::CODE_ASP0_FIRST
		&& !reg_write |=> ##1 channel_trigger[4])
		else $error("audio port event not routed");

	a_i2c_path: assert property (@(posedge clock) disable iff (!rst_n)
		i2c_event[0] && field_of(sel_ch4_7_reg, 0) == desel_pkg::CODE_I2C0_RX
		&& !reg_write |=> ##1 channel_trigger[4])
		else $error("i2c event not routed");

	a_gpio_high_path: assert property (@(posedge clock) disable iff (!rst_n)
		gpio_pin_event[8] && field_of(sel_ch12_15_reg, 0) == desel_pkg::CODE_GPIO8
		&& !reg_write |=> ##1 channel_trigger[12])
		else $error("gpio 8 event not routed");

	a_combined_gpio: assert property (@(posedge clock) disable iff (!rst_n)
		|(general_pin & combined_gpio_enable) |=> event_vec[desel_pkg::CODE_GPIO0])
		else $error("combined gpio event lost");
endmodule

// >>> desel_periph_model.sv
// desel_periph_model: peripheral modules that raise the selector's events
// assumes one clock; the bench holds fire high for one cycle per event
`timescale 1ns/1ps
module desel_periph_model (
	// system
	input wire logic clock,
	// request from the bench
	input wire logic fire,
	input wire logic [5:0] fire_code,
	// event lines, one-cycle pulses, idle low
	output logic host_to_processor_event,
	output logic timer_zero_event,
	output logic timer_one_event,
	output logic memory_interface_event,
	output logic [3:0] bsp_event,
	output logic [11:0] asp_event,
	output logic [3:0] i2c_event,
	output logic [15:0] general_pin,
	output logic [15:0] gpio_pin_event
);
	// ========================================
	// code to event line
	// one source at a time, since shared pins cannot all be live together
	wire logic [63:0] hit = 64'(fire) << fire_code;
	always @(posedge clock) begin
		host_to_processor_event <= hit[0];
		timer_zero_event <= hit[1];
		timer_one_event <= hit[2];
		memory_interface_event <= hit[3];
		gpio_pin_event <= {hit[55:48], hit[7:4], hit[11:9], 1'b0};
		// code 8 comes only through a pin, so the enable mask is exercised
		general_pin <= {hit[8], 15'h0};
		bsp_event <= hit[15:12];
		asp_event <= hit[43:32];
		i2c_event <= hit[47:44];
	end
endmodule

// >>> tb_top.sv
// tb_top: self-checking bench for the dma event selector
// assumes desel_selector and desel_periph_model compiled before it
`timescale 1ns/1ps
module tb_top;
	logic clock, rst_n, reg_write, reg_read, fire;
	logic [31:0] reg_addr, reg_wdata, reg_rdata;
	logic [5:0] fire_code;
	logic host_to_processor_event, timer_zero_event, timer_one_event, memory_interface_event;
	logic [3:0] bsp_event, i2c_event, chain_complete_code;
	logic [11:0] asp_event;
	logic [15:0] general_pin, gpio_pin_event, combined_gpio_enable;
	logic [15:0] channel_trigger, channel_code_reserved;
	int bad_count, checks_done, cycles;
	desel_selector uut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .host_to_processor_event, .timer_zero_event, .timer_one_event,
		.memory_interface_event, .bsp_event, .asp_event, .i2c_event, .general_pin,
		.gpio_pin_event, .combined_gpio_enable, .chain_complete_code, .channel_trigger,
		.channel_code_reserved);
	desel_periph_model peer (.clock, .fire, .fire_code, .host_to_processor_event,
		.timer_zero_event, .timer_one_event, .memory_interface_event, .bsp_event,
		.asp_event, .i2c_event, .general_pin, .gpio_pin_event);
	// ========================================
	// clock and hang guard
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// ========================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// trigger stands for one cycle after the third edge: peer, vector, trigger
	task automatic fire_chk(input logic [5:0] c, input logic [15:0] exp);
		@(posedge clock);
		fire <= 1'b1;
		fire_code <= c;
		@(posedge clock);
		fire <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({16'h0, channel_trigger}, {16'h0, exp});
	endtask
	// ========================================
	// scenarios
	task automatic t_reset;
		rd(desel_pkg::ADDR_SEL_CH0_3, desel_pkg::RST_SEL_CH0_3);
		rd(desel_pkg::ADDR_SEL_CH4_7, desel_pkg::RST_SEL_CH4_7);
		rd(desel_pkg::ADDR_SEL_CH12_15, desel_pkg::RST_SEL_CH12_15);
		wr(32'h01a0ff08, 32'h01010101);
		rd(32'h01a0ff08, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_mask;
		wr(desel_pkg::ADDR_SEL_CH0_3, 32'hffffffff);
		rd(desel_pkg::ADDR_SEL_CH0_3, desel_pkg::SEL_FIELD_MASK);
		chk({28'h0, channel_code_reserved[3:0]}, 32'hf);
		fire_chk(desel_pkg::CODE_HOST, 16'h0);
		fire_chk(desel_pkg::CODE_TIMER0, 16'h0);
		$display("test mask done");
	endtask
	// every valid code, rotating over the twelve mappable channels; others parked
	task automatic t_route;
		int k, ch;
		logic [31:0] a, d;
		k = 0;
		@(posedge clock);
		combined_gpio_enable <= 16'h8000;
		for (int c = 0; c < 56; c++) begin
			if (c >= 16 && c < 32) continue;
			ch = k % 12;
			if (ch >= 8) ch += 4;
			a = ch < 4 ? desel_pkg::ADDR_SEL_CH0_3 :
				ch < 8 ? desel_pkg::ADDR_SEL_CH4_7 : desel_pkg::ADDR_SEL_CH12_15;
			d = 32'h10101010;
			d[(ch % 4) * 8 +: 8] = 8'(c);
			wr(desel_pkg::ADDR_SEL_CH0_3, 32'h10101010);
			wr(desel_pkg::ADDR_SEL_CH4_7, 32'h10101010);
			wr(desel_pkg::ADDR_SEL_CH12_15, 32'h10101010);
			wr(a, d);
			rd(a, d);
			fire_chk(6'(c), 16'h1 << ch);
			k++;
		end
		$display("test route done");
	endtask
	task automatic t_gpio;
		@(posedge clock);
		combined_gpio_enable <= 16'h0;
		wr(desel_pkg::ADDR_SEL_CH0_3, 32'h10101008);
		fire_chk(desel_pkg::CODE_GPIO0, 16'h0);
		@(posedge clock);
		combined_gpio_enable <= 16'h8000;
		fire_chk(desel_pkg::CODE_GPIO0, 16'h0001);
		$display("test gpio done");
	endtask
	task automatic t_chain;
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			chain_complete_code <= 4'h1 << k;
			@(posedge clock);
			chain_complete_code <= 4'h0;
			#1 chk({16'h0, channel_trigger}, 32'h1 << (8 + k));
		end
		$display("test chain done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ========================================
	// main sequence
	initial begin
		{reg_write, reg_read, fire, fire_code, reg_addr, reg_wdata} = '0;
		{chain_complete_code, combined_gpio_enable} = '0;
		// a real falling edge later, so the reset branch runs whatever the start order
		rst_n = 1'b1;
		#5 rst_n = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_mask();
		t_route();
		t_gpio();
		t_chain();
		report_and_stop();
	end
endmodule
